//--- src/builtin_self_test_reporter.v
// Decided for this implementation: the strobed register port and the placing of the registers.
`include "self_test_regs.vh"
`default_nettype none

module builtin_self_test_reporter #(
  parameter integer BEEP_CYCLES = `BEEP_CYC,
  parameter integer SUBTEST_CYCLES = `SUBTEST_CYC,
  parameter integer SW_BITS = 5
) (
  input wire ref_clk,
  input wire resetn,
  input wire clk_en,
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [15:0] rdata,
  input wire [SW_BITS-1:0] address_switch_bank,
  input wire [9:0] check_fail,
  input wire calibrated,
  output reg beep,
  output reg error_queue_push,
  output reg [9:0] error_queue_code,
  output reg output_drive_en,
  output reg [2:0] output_step,
  output reg normal_op
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [5:0] ST_PU = 6'h01;
  localparam [5:0] ST_HALT = 6'h02;
  localparam [5:0] ST_BYP = 6'h04;
  localparam [5:0] ST_READY = 6'h08;
  localparam [5:0] ST_IDLE = 6'h10;
  localparam [5:0] ST_RUN = 6'h20;
  localparam [31:0] BEEP_N = (BEEP_CYCLES < 1) ? 32'd1 : BEEP_CYCLES;
  localparam [31:0] SUB_N = (SUBTEST_CYCLES < 1) ? 32'd1 : SUBTEST_CYCLES;

  reg [5:0] state;
  reg [3:0] sub_idx;
  reg [31:0] sub_cnt;
  reg [9:0] err_word;
  reg [9:0] result;
  reg [9:0] active_mask;
  reg [9:0] inject;
  reg full_mode;
  reg done;
  reg [3:0] halt_idx;
  reg [31:0] beep_cnt;
  reg [3:0] beeps_left;
  reg beep_phase;
  reg [2:0] next_code;
  reg start_conf;
  reg start_full;
  wire sw_all_on = &address_switch_bank;
  wire sub_fail = check_fail[sub_idx] | inject[sub_idx] |
    ((sub_idx == `ERR_FLASH) & ~calibrated);
  wire sub_end = (sub_cnt == SUB_N - 32'd1);

  // Beep count per failing check
  always @* begin
    case (halt_idx)
      `ERR_ROM, `ERR_RAM: next_code = `BEEP_ROM;
      `ERR_FLASH: next_code = `BEEP_FLASH;
      `ERR_OPT: next_code = `BEEP_OPT;
      `ERR_POT: next_code = `BEEP_POT;
      `ERR_LOOP: next_code = `BEEP_LOOP;
      default: next_code = 3'h0;
    endcase
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 16'h0000;
      inject <= 10'h000;
      start_conf <= 1'b0;
      start_full <= 1'b0;
    end else if (clk_en) begin
      start_conf <= wr_stb && addr == `REG_CTRL && wdata[`CTRL_CONF_BIT];
      start_full <= wr_stb && addr == `REG_CTRL && wdata[`CTRL_FULL_BIT];
      if (wr_stb && addr == `REG_INJECT)
        inject <= wdata[9:0];
      if (rd_stb) begin
        case (addr)
          `REG_STATUS: rdata <= {10'h000, state == ST_READY, state == ST_BYP,
            state == ST_HALT, done && result == 10'h000, done, state == ST_RUN};
          `REG_RESULT: rdata <= {6'h00, result};
          `REG_INJECT: rdata <= {6'h00, inject};
          default: rdata <= 16'h0000;
        endcase
      end else begin
        rdata <= 16'h0000;
      end
    end
  end

  // ----------------------------------------
  // Test sequencer
  // ----------------------------------------
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_PU;
      sub_idx <= 4'h0;
      sub_cnt <= 32'd0;
      err_word <= 10'h000;
      result <= 10'h000;
      active_mask <= `CONF_MASK;
      full_mode <= 1'b0;
      done <= 1'b0;
      halt_idx <= 4'h0;
      error_queue_push <= 1'b0;
      error_queue_code <= 10'h000;
      output_drive_en <= 1'b0;
      output_step <= 3'h0;
      normal_op <= 1'b0;
    end else if (clk_en) begin
      error_queue_push <= 1'b0;
      case (state)
        // Power-up checks run in order; switches all on skip them
        ST_PU: begin
          if (sw_all_on) begin
            state <= ST_BYP;
          end else if (sub_end) begin
            sub_cnt <= 32'd0;
            if (sub_fail) begin
              halt_idx <= sub_idx;
              state <= ST_HALT;
              error_queue_push <= 1'b1;
              error_queue_code <= 10'h001 << sub_idx;
            end else if (sub_idx == `ERR_POT) begin
              sub_idx <= 4'h0;
              state <= ST_IDLE;
              normal_op <= 1'b1;
            end else begin
              sub_idx <= sub_idx + 4'h1;
            end
          end else begin
            sub_cnt <= sub_cnt + 32'd1;
          end
        end
        // Failed check repeats without end
        ST_HALT: begin
          sub_idx <= halt_idx;
          sub_cnt <= sub_end ? 32'd0 : sub_cnt + 32'd1;
        end
        // Wait for a valid address, then ready beeps
        ST_BYP: begin
          if (!sw_all_on)
            state <= ST_READY;
        end
        ST_READY: begin
          if (beeps_left == 4'h0 && !beep_phase && beep_cnt == 32'd0) begin
            state <= ST_IDLE;
            normal_op <= 1'b1;
          end
        end
        ST_IDLE: begin
          if (start_conf || start_full) begin
            state <= ST_RUN;
            full_mode <= start_full;
            active_mask <= start_full ? `FULL_MASK : `CONF_MASK;
            err_word <= 10'h000;
            done <= 1'b0;
            sub_idx <= 4'h0;
            sub_cnt <= 32'd0;
            output_drive_en <= 1'b0;
          end
        end
        // Commanded test: every subtest runs regardless of failures
        ST_RUN: begin
          // Output is driven only once the ROM, RAM, flash, optical and pot checks have passed; loop-back is not among them
          if (full_mode && sub_idx >= `ERR_MAXV && err_word[4:0] == 5'h00) begin
            output_drive_en <= 1'b1;
            output_step <= sub_idx[2:0] - 3'h5;
          end
          if (sub_end) begin
            sub_cnt <= 32'd0;
            if (sub_fail && active_mask[sub_idx]) begin
              err_word <= err_word | (10'h001 << sub_idx);
              error_queue_push <= 1'b1;
              error_queue_code <= 10'h001 << sub_idx;
            end
            if (sub_idx == (full_mode ? `ERR_QREAD : `ERR_POT)) begin
              result <= (err_word | ((sub_fail && active_mask[sub_idx]) ?
                (10'h001 << sub_idx) : 10'h000)) & active_mask;
              done <= 1'b1;
              state <= ST_IDLE;
              output_drive_en <= 1'b0;
              output_step <= 3'h0;
            end else begin
              sub_idx <= sub_idx + 4'h1;
            end
          end else begin
            sub_cnt <= sub_cnt + 32'd1;
          end
        end
        default: state <= ST_PU;
      endcase
    end
  end

  // ----------------------------------------
  // Beeper
  // ----------------------------------------
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      beep <= 1'b0;
      beep_cnt <= 32'd0;
      beeps_left <= 4'h0;
      beep_phase <= 1'b0;
    end else if (clk_en) begin
      if (state == ST_BYP) begin
        // Equal on and off intervals
        if (beep_cnt == BEEP_N - 32'd1) begin
          beep_cnt <= 32'd0;
          beep <= ~beep;
        end else begin
          beep_cnt <= beep_cnt + 32'd1;
        end
        beeps_left <= `BEEP_READY;
        beep_phase <= 1'b0;
      end else if (state == ST_HALT || state == ST_READY) begin
        if (beep_cnt != 32'd0) begin
          beep_cnt <= beep_cnt - 32'd1;
        end else if (beep_phase) begin
          beep <= 1'b0;
          beep_phase <= 1'b0;
          beep_cnt <= BEEP_N;
        end else if (beeps_left != 4'h0) begin
          beep <= 1'b1;
          beep_phase <= 1'b1;
          beeps_left <= beeps_left - 4'h1;
          beep_cnt <= BEEP_N;
        end else if (state == ST_HALT) begin
          // Pause then repeat the code
          beeps_left <= {1'b0, next_code};
          beep_cnt <= BEEP_N + BEEP_N;
        end
      end else begin
        beep <= 1'b0;
        beep_cnt <= 32'd0;
        beep_phase <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

//--- common/self_test_regs.vh
// Function
// - Error bits 0..4 flag ROM, RAM, flash, optical buffer, digital potentiometer faults
// - Bits 5..9 only set by full instrument test, never by confidence test
// - Test result is zero on pass, else nonzero up to 1023
// - Every commanded-test subtest runs even after a failure; each failure sets its bit
// - Power-up beeps: 1 ROM/RAM, 2 flash, 3 optical, 6 pot, 5 loop-back (power-up checks end at pot, so 5 never sounds)
// - A failed power-up check repeats forever, never reaching normal operation
// - Power-up test skipped when all address switches read one
// - Bypassed: beep on/off equally until switches hold a valid address
// - Confidence test checks memory, timer, optical buffer and reference
// - Confidence test leaves instrument power output unchanged
// - Full test drives output limits, current mode at 1 V, readback both scales
// - Uncalibrated unit reports flash fault in confidence test
// - Failures reported to error queue; power-up failures also by audible beeps
// - Switches set at power-up may give three ready beeps
`ifndef SELF_TEST_REGS_VH
`define SELF_TEST_REGS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_RESULT 4'h2
`define REG_INJECT 4'h3

// ----------------------------------------
// Fields
// ----------------------------------------
`define CTRL_CONF_BIT 0
`define CTRL_FULL_BIT 1
`define STAT_BUSY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_PASS_BIT 2
`define STAT_HALT_BIT 3
`define STAT_BYP_BIT 4
`define STAT_READY_BIT 5
`define ERR_ROM 4'h0
`define ERR_RAM 4'h1
`define ERR_FLASH 4'h2
`define ERR_OPT 4'h3
`define ERR_POT 4'h4
`define ERR_LOOP 4'h5
`define ERR_MAXV 4'h6
`define ERR_MINV 4'h7
`define ERR_QVOLT 4'h8
`define ERR_QREAD 4'h9
`define CONF_MASK 10'h01F
`define FULL_MASK 10'h3FF

// ----------------------------------------
// Beep codes and timing
// ----------------------------------------
`define BEEP_ROM 3'h1
`define BEEP_FLASH 3'h2
`define BEEP_OPT 3'h3
`define BEEP_LOOP 3'h5
`define BEEP_POT 3'h6
`define BEEP_READY 3'h3
`define CLK_HZ 50000000
`define BEEP_MS 100
`define BEEP_CYC ((`CLK_HZ / 1000) * `BEEP_MS)
`define SUBTEST_CYC 16

`endif

//--- verif/bus_host.sv
`default_nettype none
module bus_host (
  input wire logic ref_clk,
  input wire logic [15:0] rdata,
  output logic [3:0] addr,
  output logic [15:0] wdata,
  output logic wr_stb,
  output logic rd_stb
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus from time zero
  initial begin
    addr = 4'h0;
    wdata = 16'h0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  // Read data taken in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge ref_clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask
endmodule
`default_nettype wire

//--- verif/builtin_self_test_reporter_chk.sv
`default_nettype none
module self_test_chk #(
  parameter integer BEEP_CYCLES = 4,
  parameter integer SW_BITS = 5
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic rd_stb,
  input wire logic [15:0] rdata,
  input wire logic [SW_BITS-1:0] address_switch_bank,
  input wire logic beep,
  input wire logic error_queue_push,
  input wire logic [9:0] error_queue_code,
  input wire logic output_drive_en,
  input wire logic [2:0] output_step,
  input wire logic normal_op
);
  logic [7:0] high_run;
  wire bypass = &address_switch_bank && !normal_op;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Failure seen before normal operation
  sequence s_up_fail;
    error_queue_push && !normal_op;
  endsequence
  // Cycles the beep has been high
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn) high_run <= 8'h00;
    else high_run <= beep ? high_run + 8'h01 : 8'h00;
  a_beep_even: assert property (bypass && $fell(beep) |-> high_run == BEEP_CYCLES)
    else $error("bypass beep length wrong");
  a_bypass_hold: assert property (bypass |=> !normal_op)
    else $error("bypass left early");
  a_halt_hold: assert property (s_up_fail |=> !normal_op)
    else $error("halted test resumed");
  a_halt_beep: assert property (s_up_fail |-> ##[0:200] beep)
    else $error("no beep after failure");
  a_drive_step: assert property (output_drive_en |-> output_step inside {[3'h1:3'h4]})
    else $error("drive outside steps");
  a_drive_normal: assert property (output_drive_en |-> normal_op)
    else $error("drive outside test");
  a_code_onehot: assert property (error_queue_push |-> $onehot(error_queue_code))
    else $error("queue code not one-hot");
  a_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 16'h0000)
    else $error("read data outside read");
endmodule
bind builtin_self_test_reporter self_test_chk #(.BEEP_CYCLES(BEEP_CYCLES), .SW_BITS(SW_BITS)) chk (
  .ref_clk(ref_clk), .resetn(resetn), .rd_stb(rd_stb), .rdata(rdata),
  .address_switch_bank(address_switch_bank), .beep(beep), .error_queue_push(error_queue_push),
  .error_queue_code(error_queue_code), .output_drive_en(output_drive_en),
  .output_step(output_step), .normal_op(normal_op));
`default_nettype wire

//--- verif/test_builtin_self_test_reporter.sv
`default_nettype none
module test_builtin_self_test_reporter;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, resetn, clk_en, wr_stb, rd_stb, cal, beep, push, normal_op, drv, seen;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, d;
  logic [4:0] sw;
  logic [9:0] fail, code, e;
  logic [2:0] step;
  int mismatches, checks, cycles, i;
  // Rows: full, calibrated, failing subtests
  logic [11:0] rows [7] = '{12'h400, 12'h7FF, 12'hFFF, 12'hE00, 12'h000, 12'hE60, 12'h800};
  builtin_self_test_reporter #(.BEEP_CYCLES(4), .SUBTEST_CYCLES(2)) DUT (
    .ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .address_switch_bank(sw),
    .check_fail(fail), .calibrated(cal), .beep(beep), .error_queue_push(push),
    .error_queue_code(code), .output_drive_en(drv), .output_step(step), .normal_op(normal_op));
  bus_host host (.ref_clk(ref_clk), .rdata(rdata), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Hang guard and output drive monitor
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (drv === 1'b1) seen <= 1'b1;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    checks++;
    if (g !== x) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic restart(input logic [4:0] s, input logic [9:0] f);
    @(posedge ref_clk);
    resetn <= 1'b0;
    sw <= s;
    fail <= f;
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int k = 0; k < 300 && normal_op !== 1'b1; k++) @(posedge ref_clk);
  endtask
  // Start a test and read its result once done
  task automatic run(input logic [15:0] cmd);
    host.wr(4'h0, cmd);
    repeat (2) @(posedge ref_clk);
    d = 16'h0000;
    for (int k = 0; k < 100 && d[1] !== 1'b1; k++) host.rd(4'h1, d);
    host.rd(4'h2, d);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    {resetn, clk_en, cal, seen, sw, fail} = {4'h6, 5'h06, 10'h000};
    {mismatches, checks, cycles} = '0;
    restart(5'h06, 10'h000);
    chk("ready", 16'h0001, {15'h0000, normal_op});
    for (i = 0; i < 7; i++) begin
      cal <= rows[i][10];
      fail <= rows[i][9:0];
      seen <= 1'b0;
      run({14'h0000, rows[i][11], !rows[i][11]});
      e = rows[i][11] ? rows[i][9:0] : rows[i][9:0] & 10'h01F;
      e = e | (rows[i][10] ? 10'h000 : 10'h004);
      chk("result", {6'h00, e}, d);
      chk("drive", {15'h0000, rows[i][11] && rows[i][4:0] == 5'h00 && rows[i][10]},
        {15'h0000, seen});
    end
    host.wr(4'h0, 16'h0001);
    run(16'h0002);
    chk("busy start", 16'h0004, d);
    host.rd(4'hF, d);
    chk("unmapped", 16'h0000, d);
    restart(5'h1F, 10'h000);
    chk("bypass", 16'h0000, {15'h0000, normal_op});
    sw <= 5'h06;
    repeat (200) @(posedge ref_clk);
    chk("bypass exit", 16'h0001, {15'h0000, normal_op});
    restart(5'h06, 10'h008);
    chk("halt", 16'h0000, {15'h0000, normal_op});
    host.rd(4'h1, d);
    chk("halt flag", 16'h0001, {15'h0000, d[3]});
    final_report();
  end
endmodule
`default_nettype wire
